//--- core/pwc_dev.sv
// Purpose: Device end; decodes host words to fixed point, encodes replies.
// Assumes: Host keeps the word formats; one word per valid cycle at most.
// Notes:   Fixed-point values carry PWC_FRAC fraction bits, two's complement.
`timescale 1ns/1ns
`default_nettype none
module pwc_dev (
  input wire logic clk_sys,
  input wire logic srst,
  pwc_if.dev_mp link,
  output logic dec_valid,
  output logic signed [47:0] dec_value,
  output pwc_pkg::pwc_fmt_type dec_fmt,
  output logic [15:0] dec_raw,
  output logic dec_is_raw,
  output logic dec_bad_fmt,
  input wire logic enc_valid,
  input wire logic signed [47:0] enc_value,
  input wire logic [15:0] enc_raw,
  input wire pwc_pkg::pwc_fmt_type enc_fmt,
  output logic enc_sat
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode functions

  // Exponent -16..15 maps to a left shift of 0..31
  function automatic logic signed [47:0] dec_linear(input logic [15:0] w);
    logic signed [47:0] mant;
    logic [4:0] sh;
    mant = {{37{w[pwc_pkg::PWC_MANT_MSB]}}, w[pwc_pkg::PWC_MANT_MSB:0]};  // [RL2]
    sh = {~w[pwc_pkg::PWC_EXP_MSB], w[pwc_pkg::PWC_EXP_MSB-1:pwc_pkg::PWC_EXP_LSB]};  // [RL1]
    return mant <<< sh;  // [RL2]
  endfunction

  function automatic logic signed [47:0] dec_fixed_exp(input logic [15:0] w);
    logic signed [47:0] u;
    u = {32'h0000_0000, w};  // [RL3]
    return u <<< pwc_pkg::PWC_FIXED_SHIFT;  // [RL4]
  endfunction

  function automatic logic signed [47:0] dec_integer(input logic [15:0] w);
    logic signed [47:0] u;
    u = {32'h0000_0000, w};
    return u <<< pwc_pkg::PWC_FRAC;  // [RL5]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Encode functions

  // Smallest exponent whose mantissa fits keeps the most precision;
  // bits below the chosen scale are truncated toward minus infinity.
  function automatic logic [16:0] enc_linear(input logic signed [47:0] v);
    logic signed [47:0] c;
    logic found;
    logic [16:0] r;
    found = 1'b0;
    r = {1'b1, pwc_pkg::PWC_EXP_MAX, pwc_pkg::PWC_MANT_POS_MAX};
    if (v[47]) begin
      r = {1'b1, pwc_pkg::PWC_EXP_MAX, pwc_pkg::PWC_MANT_NEG_MAX};
    end
    for (int k = 0; k < 32; k++) begin
      c = v >>> k;
      if (!found && (c[47:10] == {38{c[10]}})) begin
        found = 1'b1;
        r = {1'b0, 5'(k) ^ 5'h10, c[10:0]};  // [RL1] [RL2]
      end
    end
    return r;
  endfunction

  function automatic logic [16:0] enc_unsigned(input logic signed [47:0] v, input logic [5:0] sh);
    logic signed [47:0] c;
    logic [16:0] r;
    c = v >>> sh;
    if (c[47]) begin
      r = {1'b1, 16'h0000};
    end else if (c[47:16] != 32'h0000_0000) begin
      r = {1'b1, pwc_pkg::PWC_U16_MAX};
    end else begin
      r = {1'b0, c[15:0]};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational conversion of the incoming word

  logic signed [47:0] next_dec_value;
  logic [15:0] next_dec_raw;
  logic next_dec_is_raw;
  logic next_dec_bad;

  always_comb begin  // [RL7]
    next_dec_value = 48'h0000_0000_0000;
    next_dec_raw = link.h2d_word;
    next_dec_is_raw = 1'b0;
    next_dec_bad = 1'b0;
    case (link.h2d_fmt)
      pwc_pkg::pwc_linear_exp5_mant11_format: begin
        next_dec_value = dec_linear(link.h2d_word);  // [RL1] [RL2]
      end
      pwc_pkg::pwc_linear_unsigned_fixed_exp_format: begin
        next_dec_value = dec_fixed_exp(link.h2d_word);  // [RL3] [RL4]
      end
      pwc_pkg::pwc_plain_unsigned_word_format: begin
        next_dec_value = dec_integer(link.h2d_word);  // [RL5]
      end
      pwc_pkg::pwc_register_word_format: begin
        next_dec_is_raw = 1'b1;  // [RL6]
      end
      pwc_pkg::pwc_register_byte_format: begin
        next_dec_raw = {8'h00, link.h2d_word[pwc_pkg::PWC_BYTE_W-1:0]};  // [RL6]
        next_dec_is_raw = 1'b1;
      end
      default: begin
        // Unknown format: flag it, pass the word raw, no conversion
        next_dec_bad = 1'b1;
        next_dec_is_raw = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combinational conversion of the outgoing word

  logic [15:0] next_word;
  logic next_sat;
  logic [16:0] lin_r;
  logic [16:0] fix_r;
  logic [16:0] int_r;

  assign lin_r = enc_linear(enc_value);
  assign fix_r = enc_unsigned(enc_value, 6'(pwc_pkg::PWC_FIXED_SHIFT));  // [RL4]
  assign int_r = enc_unsigned(enc_value, 6'(pwc_pkg::PWC_FRAC));  // [RL5]

  always_comb begin  // [RL7]
    next_word = pwc_pkg::PWC_WORD_RESET;
    next_sat = 1'b0;
    case (enc_fmt)
      pwc_pkg::pwc_linear_exp5_mant11_format: begin
        next_word = lin_r[15:0];  // [RL1] [RL2]
        next_sat = lin_r[16];
      end
      pwc_pkg::pwc_linear_unsigned_fixed_exp_format: begin
        next_word = fix_r[15:0];  // [RL3] [RL4]
        next_sat = fix_r[16];
      end
      pwc_pkg::pwc_plain_unsigned_word_format: begin
        next_word = int_r[15:0];  // [RL5]
        next_sat = int_r[16];
      end
      pwc_pkg::pwc_register_word_format: begin
        next_word = enc_raw;  // [RL6]
      end
      pwc_pkg::pwc_register_byte_format: begin
        next_word = {8'h00, enc_raw[pwc_pkg::PWC_BYTE_W-1:0]};  // [RL6]
      end
      default: begin
        next_word = pwc_pkg::PWC_WORD_RESET;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded result registers

  always_ff @(posedge clk_sys) begin
    if (srst) begin  // [RL7]
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= link.h2d_valid;
    end
  end

  // Results hold their last value between words
  always_ff @(posedge clk_sys) begin
    if (srst) begin  // [RL7]
      dec_value <= 48'h0000_0000_0000;
      dec_fmt <= pwc_pkg::pwc_linear_exp5_mant11_format;
      dec_raw <= pwc_pkg::PWC_WORD_RESET;
      dec_is_raw <= 1'b0;
      dec_bad_fmt <= 1'b0;
    end else if (link.h2d_valid) begin
      dec_value <= next_dec_value;
      dec_fmt <= link.h2d_fmt;
      dec_raw <= next_dec_raw;
      dec_is_raw <= next_dec_is_raw;
      dec_bad_fmt <= next_dec_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing word registers

  always_ff @(posedge clk_sys) begin
    if (srst) begin  // [RL7]
      link.d2h_valid <= 1'b0;
    end else begin
      link.d2h_valid <= enc_valid;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin  // [RL7]
      link.d2h_word <= pwc_pkg::PWC_WORD_RESET;
      link.d2h_fmt <= pwc_pkg::pwc_linear_exp5_mant11_format;
      enc_sat <= 1'b0;
    end else if (enc_valid) begin
      link.d2h_word <= next_word;
      link.d2h_fmt <= enc_fmt;
      enc_sat <= next_sat;
    end
  end

endmodule
`default_nettype wire

//--- inc/pwc_pkg.sv
// Purpose: Shared constants and types for the power telemetry word codec.
// Assumes: One clock domain; both link ends include this package by scope.
// Notes:   Internal values are signed fixed point with PWC_FRAC fraction bits.
//
// Overview of operation
// (RL1) Linear word: top five bits, signed exponent
// (RL2) Linear word: low eleven bits, signed mantissa
// (RL3) Sixteen-bit linear word: whole word unsigned mantissa
// (RL4) Sixteen-bit linear exponent fixed at minus twelve
// (RL5) Integer word: unsigned value, no scaling
// (RL6) Register words: raw sixteen or eight bits
// (RL7) Combinational conversion, registered results, cleared by reset
package pwc_pkg;

  localparam int PWC_WORD_W = 16;
  localparam int PWC_BYTE_W = 8;
  localparam int PWC_EXP_W = 5;
  localparam int PWC_MANT_W = 11;
  localparam int PWC_EXP_LSB = 11;
  localparam int PWC_EXP_MSB = 15;
  localparam int PWC_MANT_MSB = 10;

  // Fraction bits chosen equal to the most negative exponent so decode is exact
  localparam int PWC_FRAC = 16;
  localparam int PWC_VAL_W = 48;

  localparam logic signed [4:0] PWC_FIXED_EXP = 5'sh14;  // -12
  localparam int PWC_FIXED_SHIFT = 4;                     // PWC_FRAC - 12
  localparam int PWC_EXP_BIAS_SHIFT = 16;                 // exponent + 16 = shift

  localparam logic [15:0] PWC_WORD_RESET = 16'h0000;
  localparam logic [15:0] PWC_U16_MAX = 16'hFFFF;
  localparam logic [4:0] PWC_EXP_MAX = 5'h0F;
  localparam logic [10:0] PWC_MANT_POS_MAX = 11'h3FF;
  localparam logic [10:0] PWC_MANT_NEG_MAX = 11'h400;

  typedef enum logic [2:0] {
    pwc_linear_exp5_mant11_format = 3'h0,
    pwc_linear_unsigned_fixed_exp_format = 3'h1,
    pwc_plain_unsigned_word_format = 3'h2,
    pwc_register_word_format = 3'h3,
    pwc_register_byte_format = 3'h4
  } pwc_fmt_type;

endpackage

//--- inc/pwc_if.sv
// Purpose: Word link between the host end and the device end of the codec.
// Assumes: Both ends run on clk_sys; all signals are driven from flip-flops.
// Notes:   The testbench instantiates this and joins the two ends.
`timescale 1ns/1ns
`default_nettype none
interface pwc_if (
  input wire logic clk_sys
);
  logic h2d_valid;
  logic [15:0] h2d_word;
  pwc_pkg::pwc_fmt_type h2d_fmt;
  logic d2h_valid;
  logic [15:0] d2h_word;
  pwc_pkg::pwc_fmt_type d2h_fmt;

  modport dev_mp (
    input h2d_valid,
    input h2d_word,
    input h2d_fmt,
    output d2h_valid,
    output d2h_word,
    output d2h_fmt
  );

  modport host_mp (
    output h2d_valid,
    output h2d_word,
    output h2d_fmt,
    input d2h_valid,
    input d2h_word,
    input d2h_fmt
  );
endinterface
`default_nettype wire

//--- core/pwc_host.sv
// Purpose: Host end; sends command words and splits returned words.
// Assumes: Device keeps the word formats; one word per valid cycle at most.
// Notes:   Returned fields are shown as exponent and mantissa, not scaled.
`timescale 1ns/1ns
`default_nettype none
module pwc_host (
  input wire logic clk_sys,
  input wire logic srst,
  pwc_if.host_mp link,
  input wire logic tx_valid,
  input wire logic [15:0] tx_word,
  input wire pwc_pkg::pwc_fmt_type tx_fmt,
  output logic rx_valid,
  output logic [15:0] rx_word,
  output pwc_pkg::pwc_fmt_type rx_fmt,
  output logic signed [4:0] rx_exp,
  output logic signed [16:0] rx_mant
);

  ////////////////////////////////////////////////////////////////////////////
  // Field split of a returned word

  logic signed [4:0] next_exp;
  logic signed [16:0] next_mant;

  // Mantissa is 17 bits so an unsigned 16-bit value stays positive
  always_comb begin
    next_exp = 5'sh00;
    next_mant = {1'b0, link.d2h_word};
    case (link.d2h_fmt)
      pwc_pkg::pwc_linear_exp5_mant11_format: begin
        next_exp = link.d2h_word[pwc_pkg::PWC_EXP_MSB:pwc_pkg::PWC_EXP_LSB];  // [RL1]
        next_mant = {{6{link.d2h_word[pwc_pkg::PWC_MANT_MSB]}}, link.d2h_word[pwc_pkg::PWC_MANT_MSB:0]};  // [RL2]
      end
      pwc_pkg::pwc_linear_unsigned_fixed_exp_format: begin
        next_exp = pwc_pkg::PWC_FIXED_EXP;  // [RL4]
      end
      pwc_pkg::pwc_plain_unsigned_word_format: begin
        next_exp = 5'sh00;  // [RL5]
      end
      pwc_pkg::pwc_register_byte_format: begin
        next_mant = {9'h000, link.d2h_word[pwc_pkg::PWC_BYTE_W-1:0]};  // [RL6]
      end
      default: begin
        next_exp = 5'sh00;  // [RL6]
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing words

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link.h2d_valid <= 1'b0;
      link.h2d_word <= pwc_pkg::PWC_WORD_RESET;
      link.h2d_fmt <= pwc_pkg::pwc_linear_exp5_mant11_format;
    end else begin
      link.h2d_valid <= tx_valid;
      if (tx_valid) begin
        // Byte-wide register words keep the upper byte clear on the link
        if (tx_fmt == pwc_pkg::pwc_register_byte_format) begin
          link.h2d_word <= {8'h00, tx_word[pwc_pkg::PWC_BYTE_W-1:0]};  // [RL6]
        end else begin
          link.h2d_word <= tx_word;
        end
        link.h2d_fmt <= tx_fmt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Returned words

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= link.d2h_valid;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_word <= pwc_pkg::PWC_WORD_RESET;
      rx_fmt <= pwc_pkg::pwc_linear_exp5_mant11_format;
      rx_exp <= 5'sh00;
      rx_mant <= 17'sh00000;
    end else if (link.d2h_valid) begin
      rx_word <= link.d2h_word;
      rx_fmt <= link.d2h_fmt;
      rx_exp <= next_exp;
      rx_mant <= next_mant;
    end
  end

endmodule
`default_nettype wire

//--- verification/pwc_link_asserts.sv
// Purpose: Watches the word link between the two codec ends.
// Assumes: One clock; srst synchronous, active high.
// Notes:   Sees only link signals, so only rules about the wire are checked here.
`timescale 1ns/1ns
`default_nettype none
module pwc_link_asserts (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic h2d_valid,
  input wire logic [15:0] h2d_word,
  input wire pwc_pkg::pwc_fmt_type h2d_fmt,
  input wire logic d2h_valid,
  input wire logic [15:0] d2h_word,
  input wire pwc_pkg::pwc_fmt_type d2h_fmt
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  sequence s_link_idle;
    !h2d_valid && !d2h_valid && h2d_word == 16'h0000 && d2h_word == 16'h0000;
  endsequence
  sequence s_lin_reply;
    d2h_valid && d2h_fmt == pwc_pkg::pwc_linear_exp5_mant11_format;
  endsequence
  ////////////////////////////////////////
  a_reset_link_idle: assert property ($fell(srst) |-> s_link_idle)
    else $error("link not idle after reset");
  // Past sample may predate a one-edge reset, hence the srst guard
  a_h2d_word_hold: assert property (!h2d_valid && !$past(srst) |-> $stable(h2d_word) && $stable(h2d_fmt))
    else $error("host word changed without valid");
  a_d2h_word_hold: assert property (!d2h_valid && !$past(srst) |-> $stable(d2h_word) && $stable(d2h_fmt))
    else $error("device word changed without valid");
  a_h2d_byte_upper: assert property (h2d_valid && h2d_fmt == pwc_pkg::pwc_register_byte_format
    |-> h2d_word[15:8] == 8'h00)
    else $error("host byte word has upper bits set");
  a_d2h_byte_upper: assert property (d2h_valid && d2h_fmt == pwc_pkg::pwc_register_byte_format
    |-> d2h_word[15:8] == 8'h00)
    else $error("device byte word has upper bits set");
  a_lin_mant_norm: assert property (s_lin_reply ##0 d2h_word[15:11] != 5'h10
    |-> d2h_word[10] != d2h_word[9])
    else $error("linear reply exponent not the smallest");
  a_lin_zero_exp: assert property (s_lin_reply ##0 d2h_word[10:0] == 11'h000
    |-> d2h_word[15:11] == 5'h10)
    else $error("linear zero not sent with lowest exponent");
endmodule
`default_nettype wire

//--- verification/tb_power_telemetry_word_format_codec.sv
// Purpose: Drives both codec ends from their user sides and checks results.
// Assumes: One word in flight at a time; answers come within a few cycles.
// Notes:   Expected values are hand-worked fixed point with 16 fraction bits.
`timescale 1ns/1ns
`default_nettype none
module tb_power_telemetry_word_format_codec;
  typedef struct packed {logic [15:0] w; logic [2:0] f; logic [47:0] v;
    logic [15:0] r; logic ir; logic bf;} pwc_dec_case_type;
  typedef struct packed {logic [47:0] v; logic [2:0] f; logic [15:0] r;
    logic [15:0] w; logic [4:0] e; logic [16:0] m; logic s;} pwc_enc_case_type;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic tx_valid = 1'b0;
  logic [15:0] tx_word = 16'h0000;
  pwc_pkg::pwc_fmt_type tx_fmt = pwc_pkg::pwc_linear_exp5_mant11_format;
  logic rx_valid, dec_valid, dec_is_raw, dec_bad_fmt, enc_sat;
  logic [15:0] rx_word, dec_raw;
  pwc_pkg::pwc_fmt_type rx_fmt, dec_fmt;
  logic signed [4:0] rx_exp;
  logic signed [16:0] rx_mant;
  logic signed [47:0] dec_value;
  logic enc_valid = 1'b0;
  logic signed [47:0] enc_value = 48'h0;
  logic [15:0] enc_raw = 16'h0000;
  pwc_pkg::pwc_fmt_type enc_fmt = pwc_pkg::pwc_linear_exp5_mant11_format;
  int err_total = 0;
  int checked = 0;
  pwc_dec_case_type dec_tab [10] = '{
    '{16'h9807, 3'h0, 48'h38, 16'h9807, 1'h0, 1'h0},
    '{16'h07FF, 3'h0, 48'hFFFF_FFFF_0000, 16'h07FF, 1'h0, 1'h0},
    '{16'h7801, 3'h0, 48'h8000_0000, 16'h7801, 1'h0, 1'h0},
    '{16'h0400, 3'h0, 48'hFFFF_FC00_0000, 16'h0400, 1'h0, 1'h0},
    '{16'h9800, 3'h1, 48'h9_8000, 16'h9800, 1'h0, 1'h0},
    '{16'hFFFF, 3'h1, 48'hF_FFF0, 16'hFFFF, 1'h0, 1'h0},
    '{16'h9807, 3'h2, 48'h9807_0000, 16'h9807, 1'h0, 1'h0},
    '{16'hA5C3, 3'h3, 48'h0, 16'hA5C3, 1'h1, 1'h0},
    '{16'hA5C3, 3'h4, 48'h0, 16'h00C3, 1'h1, 1'h0},
    '{16'h1234, 3'h5, 48'h0, 16'h1234, 1'h1, 1'h1}};
  pwc_enc_case_type enc_tab [12] = '{
    '{48'h9_8000, 3'h1, 16'h0, 16'h9800, 5'h14, 17'h09800, 1'h0},
    '{48'h10_0000, 3'h1, 16'h0, 16'hFFFF, 5'h14, 17'h0FFFF, 1'h1},
    '{48'hFFFF_FFFF_0000, 3'h1, 16'h0, 16'h0000, 5'h14, 17'h0, 1'h1},
    '{48'h38, 3'h0, 16'h0, 16'h8038, 5'h10, 17'h00038, 1'h0},
    '{48'h0, 3'h0, 16'h0, 16'h8000, 5'h10, 17'h0, 1'h0},
    '{48'h8000_0000, 3'h0, 16'h0, 16'h3200, 5'h06, 17'h00200, 1'h0},
    '{48'hFFFF_FFFF_0000, 3'h0, 16'h0, 16'hB400, 5'h16, 17'h1FC00, 1'h0},
    '{48'h7FFF_FFFF_FFFF, 3'h0, 16'h0, 16'h7BFF, 5'h0F, 17'h003FF, 1'h1},
    '{48'h9807_8000, 3'h2, 16'h0, 16'h9807, 5'h00, 17'h09807, 1'h0},
    '{48'h0, 3'h3, 16'h5AA5, 16'h5AA5, 5'h00, 17'h05AA5, 1'h0},
    '{48'h0, 3'h4, 16'h5AA5, 16'h00A5, 5'h00, 17'h000A5, 1'h0},
    // Unknown format code goes out as an all-zero word
    '{48'h0, 3'h5, 16'h1234, 16'h0000, 5'h00, 17'h00000, 1'h0}};
  ////////////////////////////////////////
  always #5 clk_sys = ~clk_sys;
  pwc_if i_pwc_if (.clk_sys(clk_sys));
  pwc_host i_pwc_host (.clk_sys(clk_sys), .srst(srst), .link(i_pwc_if.host_mp), .tx_valid(tx_valid),
    .tx_word(tx_word), .tx_fmt(tx_fmt), .rx_valid(rx_valid), .rx_word(rx_word), .rx_fmt(rx_fmt),
    .rx_exp(rx_exp), .rx_mant(rx_mant));
  pwc_dev i_pwc_dev (.clk_sys(clk_sys), .srst(srst), .link(i_pwc_if.dev_mp), .dec_valid(dec_valid),
    .dec_value(dec_value), .dec_fmt(dec_fmt), .dec_raw(dec_raw), .dec_is_raw(dec_is_raw),
    .dec_bad_fmt(dec_bad_fmt), .enc_valid(enc_valid), .enc_value(enc_value), .enc_raw(enc_raw),
    .enc_fmt(enc_fmt), .enc_sat(enc_sat));
  pwc_link_asserts i_pwc_link_asserts (.clk_sys(clk_sys), .srst(srst), .h2d_valid(i_pwc_if.h2d_valid),
    .h2d_word(i_pwc_if.h2d_word), .h2d_fmt(i_pwc_if.h2d_fmt), .d2h_valid(i_pwc_if.d2h_valid),
    .d2h_word(i_pwc_if.d2h_word), .d2h_fmt(i_pwc_if.d2h_fmt));
  ////////////////////////////////////////
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded so a lost pulse shows as a mismatch, not a hang
  task automatic wait_hi(ref logic flag);
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 8) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    cmp({47'h0, flag}, 48'h1);
  endtask
  task automatic send(input pwc_dec_case_type t);
    @(posedge clk_sys);
    #1;
    tx_valid = 1'b1;
    tx_word = t.w;
    tx_fmt = pwc_pkg::pwc_fmt_type'(t.f);
    @(posedge clk_sys);
    #1;
    tx_valid = 1'b0;
    cmp({32'h0, i_pwc_if.h2d_word}, {32'h0, t.f == 3'h4 ? {8'h00, t.w[7:0]} : t.w});
    wait_hi(dec_valid);
    cmp(dec_value, t.v);
    cmp({32'h0, dec_raw}, {32'h0, t.r});
    cmp({45'h0, dec_fmt}, {45'h0, t.f});
    cmp({46'h0, dec_is_raw, dec_bad_fmt}, {46'h0, t.ir, t.bf});
  endtask
  task automatic reply(input pwc_enc_case_type t);
    @(posedge clk_sys);
    #1;
    enc_valid = 1'b1;
    enc_value = t.v;
    enc_raw = t.r;
    enc_fmt = pwc_pkg::pwc_fmt_type'(t.f);
    @(posedge clk_sys);
    #1;
    enc_valid = 1'b0;
    wait_hi(rx_valid);
    cmp({32'h0, i_pwc_if.d2h_word}, {32'h0, t.w});
    cmp({32'h0, rx_word}, {32'h0, t.w});
    cmp({45'h0, rx_fmt}, {45'h0, t.f});
    cmp({43'h0, rx_exp}, {43'h0, t.e});
    cmp({31'h0, rx_mant}, {31'h0, t.m});
    cmp({47'h0, enc_sat}, {47'h0, t.s});
  endtask
  task automatic do_reset(input int n);
    srst = 1'b1;
    repeat (n) @(posedge clk_sys);
    #1;
    srst = 1'b0;
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    do_reset(10);
    foreach (dec_tab[i]) send(dec_tab[i]);
    // Mid-run reset must clear held results, not only the pulses
    do_reset(2);
    cmp(dec_value, 48'h0);
    cmp({32'h0, i_pwc_if.h2d_word}, 48'h0);
    cmp({45'h0, i_pwc_if.h2d_fmt}, 48'h0);
    cmp({32'h0, dec_raw}, 48'h0);
    cmp({43'h0, dec_fmt, dec_is_raw, dec_bad_fmt}, 48'h0);
    foreach (enc_tab[i]) reply(enc_tab[i]);
    wrap_up;
  end
  initial begin
    #100000;
    err_total++;
    wrap_up;
  end
endmodule
`default_nettype wire
